// [rtl/acp_params.svh]
`ifndef ACP_PARAMS_SVH
`define ACP_PARAMS_SVH

// =====================================================================
// register indices (byte address = index * 4)
`define ACP_IDX_SOFT_RESET   10'h000
`define ACP_IDX_IF_MODE      10'h007
`define ACP_IDX_CONV_POWER   10'h008
`define ACP_IDX_LANE_POWER   10'h009
`define ACP_IDX_SYNC_REF_CLK 10'h00e
`define ACP_IDX_FUSE_LOAD    10'h013
`define ACP_IDX_STATUS       10'h03f

// =====================================================================
// field positions and writable masks
`define ACP_SOFT_RESET_BIT   0
`define ACP_MAP_SEL_MSB      7
`define ACP_MAP_SEL_LSB      5
`define ACP_IF_SEL_EN_BIT    3
`define ACP_IF_MODE_MSB      2
`define ACP_IF_MODE_LSB      0
`define ACP_CONVERTER_A_POWERDOWN_BIT        2
`define ACP_CONVERTER_B_POWERDOWN_BIT        1
`define ACP_WHOLE_DEVICE_POWERDOWN_BIT   0
`define ACP_IF_MODE_MASK     8'hef
`define ACP_CONV_POWER_MASK  8'h07
`define ACP_LANE_POWER_MASK  8'h0f
`define ACP_SYNC_REF_MASK    8'hef
`define ACP_REG_RESET        8'h00

// =====================================================================
// encodings
`define ACP_MODE_ONE_LANE    3'h4
`define ACP_MODE_HALF_LANE   3'h5
`define ACP_MAP_NONE         3'h0

// =====================================================================
// timing
`define ACP_CLK_PERIOD_NS    25
`define ACP_FUSE_HOLD_NS     1000000
`define ACP_FUSE_HOLD_CYCLES (`ACP_FUSE_HOLD_NS / `ACP_CLK_PERIOD_NS)
`define ACP_HOLD_CNT_W       16

`endif

// [rtl/acp_pkg.sv]
package acp_pkg;

  // output interface arrangement, gray along two -> one -> half lane
  typedef enum logic [1:0] {
    ACP_TWO_LANE  = 2'h0,
    ACP_ONE_LANE  = 2'h1,
    ACP_HALF_LANE = 2'h3
  } acp_mode_t;

  function automatic acp_mode_t acp_eff_mode(input logic [7:0] if_ctrl);
    acp_mode_t m;
    m = ACP_TWO_LANE;
    if (if_ctrl[3]) begin
      if (if_ctrl[2:0] == 3'h4) begin
        m = ACP_ONE_LANE;
      end else if (if_ctrl[2:0] == 3'h5) begin
        m = ACP_HALF_LANE;
      end
    end
    return m;
  endfunction

endpackage

// [rtl/acp_fuse_rom.sv]
`timescale 1ns/1ps

// =====================================================================
// fuse bank: default bit mapping per interface arrangement
module acp_fuse_rom (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire acp_pkg::acp_mode_t mode,
  output logic [2:0]             map_r
);
  import acp_pkg::*;

  typedef struct packed {
    logic [2:0] map;
  } acp_rom_st_t;

  acp_rom_st_t st_r;
  acp_rom_st_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    case (mode)
      ACP_ONE_LANE:  st_nxt.map = 3'h3;
      ACP_HALF_LANE: st_nxt.map = 3'h4;
      default:       st_nxt.map = 3'h1;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign map_r = st_r.map;
endmodule

// [rtl/acp_power_out.sv]
`timescale 1ns/1ps
`include "acp_params.svh"

// =====================================================================
// registered power-down controls toward the analog side
module acp_power_out (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [7:0] conv_ctrl,
  input  wire logic [7:0] lane_ctrl,
  output logic            converter_a_powerdown,
  output logic            converter_b_powerdown,
  output logic            whole_device_powerdown,
  output logic [3:0]      lane_powerdown
);
  import acp_pkg::*;

  typedef struct packed {
    logic       pd_a;
    logic       pd_b;
    logic       pd_all;
    logic [3:0] lanes;
  } acp_pwr_st_t;

  acp_pwr_st_t st_r;
  acp_pwr_st_t st_nxt;

  always_comb begin
    st_nxt        = st_r;
    st_nxt.pd_a   = conv_ctrl[`ACP_CONVERTER_A_POWERDOWN_BIT];
    st_nxt.pd_b   = conv_ctrl[`ACP_CONVERTER_B_POWERDOWN_BIT];
    st_nxt.pd_all = conv_ctrl[`ACP_WHOLE_DEVICE_POWERDOWN_BIT];
    // lanes follow only their own bits, never the interface arrangement
    st_nxt.lanes  = lane_ctrl[3:0];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign converter_a_powerdown  = st_r.pd_a;
  assign converter_b_powerdown  = st_r.pd_b;
  assign whole_device_powerdown = st_r.pd_all;
  assign lane_powerdown         = st_r.lanes;
endmodule

// [rtl/acp_regbank.sv]
// The APB slave port was left to the implementer.
`timescale 1ns/1ps
`include "acp_params.svh"

// Function
// - reset bit restores defaults, then self-clears
// - mapping field picks output bit arrangement
// - default mapping from fuses after fuse load
// - interface register bit 3 enables mode selection
// - mode field 100/101 acts only when enabled
// - power bit 2 powers down converter A
// - power bit 1 powers down converter B
// - power bit 0 powers down whole device
// - lane bits power down their own lanes
// - lanes A1, B1 never auto powered down
// - lane B0 never auto powered down
// - all fields reset to zero
module acp_regbank #(
  parameter int FUSE_HOLD_CYCLES = `ACP_FUSE_HOLD_CYCLES
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output acp_pkg::acp_mode_t active_mode,
  output logic [2:0]       active_mapping,
  output logic             mapping_loaded,
  output logic             fuse_hold_met,
  output logic [7:0]       sync_ref_clock_ctrl,
  output logic             converter_a_powerdown,
  output logic             converter_b_powerdown,
  output logic             whole_device_powerdown,
  output logic [3:0]       lane_powerdown
);
  import acp_pkg::*;

  localparam logic [`ACP_HOLD_CNT_W-1:0] HOLD_CNT = `ACP_HOLD_CNT_W'(FUSE_HOLD_CYCLES);

  // ===================================================================
  // state
  typedef struct packed {
    logic                       soft_rst;
    logic [7:0]                 if_ctrl;
    logic [7:0]                 conv_ctrl;
    logic [7:0]                 lane_ctrl;
    logic [7:0]                 sync_ref;
    logic                       fuse_ctl;
    logic [`ACP_HOLD_CNT_W-1:0] hold_cnt;
    logic                       hold_met;
    logic                       loaded;
    acp_mode_t                  mode;
    logic [2:0]                 map;
    logic                       pready;
    logic                       pslverr;
    logic [31:0]                prdata;
  } acp_st_t;

  acp_st_t    st_r;
  acp_st_t    st_nxt;
  logic [2:0] fuse_map;

  acp_fuse_rom u_fuse (
    .pclk    (pclk),
    .presetn (presetn),
    .mode    (acp_eff_mode(st_r.if_ctrl)),
    .map_r   (fuse_map)
  );

  acp_power_out u_pwr (
    .pclk                   (pclk),
    .presetn                (presetn),
    .conv_ctrl              (st_r.conv_ctrl),
    .lane_ctrl              (st_r.lane_ctrl),
    .converter_a_powerdown  (converter_a_powerdown),
    .converter_b_powerdown  (converter_b_powerdown),
    .whole_device_powerdown (whole_device_powerdown),
    .lane_powerdown         (lane_powerdown)
  );

  // ===================================================================
  // bus decode
  logic       setup;
  logic       wr_go;
  logic [9:0] idx;
  logic       aligned;

  assign setup   = psel && !penable;
  assign wr_go   = psel && penable && st_r.pready && pwrite && !st_r.pslverr;
  assign idx     = paddr[11:2];
  assign aligned = (paddr[1:0] == 2'h0);

  function automatic logic mapped(input logic [9:0] i);
    return (i == `ACP_IDX_SOFT_RESET) || (i == `ACP_IDX_IF_MODE) || (i == `ACP_IDX_CONV_POWER) ||
           (i == `ACP_IDX_LANE_POWER) || (i == `ACP_IDX_SYNC_REF_CLK) ||
           (i == `ACP_IDX_FUSE_LOAD) || (i == `ACP_IDX_STATUS);
  endfunction

  // ===================================================================
  // next state
  always_comb begin
    st_nxt         = st_r;
    st_nxt.pready  = setup;
    st_nxt.pslverr = setup && !(aligned && mapped(idx));
    if (setup) begin
      st_nxt.prdata = 32'h0;
      if (idx == `ACP_IDX_SOFT_RESET) begin
        st_nxt.prdata[0] = st_r.soft_rst;
      end else if (idx == `ACP_IDX_IF_MODE) begin
        st_nxt.prdata[7:0] = st_r.if_ctrl;
      end else if (idx == `ACP_IDX_CONV_POWER) begin
        st_nxt.prdata[7:0] = st_r.conv_ctrl;
      end else if (idx == `ACP_IDX_LANE_POWER) begin
        st_nxt.prdata[7:0] = st_r.lane_ctrl;
      end else if (idx == `ACP_IDX_SYNC_REF_CLK) begin
        st_nxt.prdata[7:0] = st_r.sync_ref;
      end else if (idx == `ACP_IDX_FUSE_LOAD) begin
        st_nxt.prdata[0] = st_r.fuse_ctl;
      end else if (idx == `ACP_IDX_STATUS) begin
        st_nxt.prdata[7:0] = {1'b0, st_r.map, st_r.mode, st_r.hold_met, st_r.loaded};
      end
    end

    // interface arrangement follows the enable live
    st_nxt.mode = acp_eff_mode(st_r.if_ctrl);

    // fuse load: hold time is counted so software can see it was met
    if (st_r.fuse_ctl) begin
      if (st_r.hold_cnt != HOLD_CNT) begin
        st_nxt.hold_cnt = st_r.hold_cnt + `ACP_HOLD_CNT_W'(1);
      end else begin
        st_nxt.hold_met = 1'b1;
      end
    end

    if (wr_go) begin
      // reserved bits are dropped, so they always read back as zero
      if (idx == `ACP_IDX_SOFT_RESET) begin
        st_nxt.soft_rst = pwdata[`ACP_SOFT_RESET_BIT];
      end else if (idx == `ACP_IDX_IF_MODE) begin
        st_nxt.if_ctrl = pwdata[7:0] & `ACP_IF_MODE_MASK;
      end else if (idx == `ACP_IDX_CONV_POWER) begin
        st_nxt.conv_ctrl = pwdata[7:0] & `ACP_CONV_POWER_MASK;
      end else if (idx == `ACP_IDX_LANE_POWER) begin
        st_nxt.lane_ctrl = pwdata[7:0] & `ACP_LANE_POWER_MASK;
      end else if (idx == `ACP_IDX_SYNC_REF_CLK) begin
        st_nxt.sync_ref = pwdata[7:0] & `ACP_SYNC_REF_MASK;
      end else if (idx == `ACP_IDX_FUSE_LOAD) begin
        st_nxt.fuse_ctl = pwdata[0];
        if (pwdata[0] && !st_r.fuse_ctl) begin
          st_nxt.hold_cnt = '0;
          st_nxt.hold_met = 1'b0;
        end
        // falling edge of the control bit completes the load
        if (!pwdata[0] && st_r.fuse_ctl) begin
          st_nxt.loaded = 1'b1;
          if (st_r.if_ctrl[`ACP_MAP_SEL_MSB:`ACP_MAP_SEL_LSB] != `ACP_MAP_NONE) begin
            st_nxt.map = st_r.if_ctrl[`ACP_MAP_SEL_MSB:`ACP_MAP_SEL_LSB];
          end else begin
            st_nxt.map = fuse_map;
          end
        end
      end
    end

    // soft reset clears everything but the bus answer; bit reads 0 after
    if (st_r.soft_rst) begin
      st_nxt.soft_rst  = 1'b0;
      st_nxt.if_ctrl   = `ACP_REG_RESET;
      st_nxt.conv_ctrl = `ACP_REG_RESET;
      st_nxt.lane_ctrl = `ACP_REG_RESET;
      st_nxt.sync_ref  = `ACP_REG_RESET;
      st_nxt.fuse_ctl  = 1'b0;
      st_nxt.hold_cnt  = '0;
      st_nxt.hold_met  = 1'b0;
      st_nxt.loaded    = 1'b0;
      st_nxt.mode      = ACP_TWO_LANE;
      st_nxt.map       = `ACP_MAP_NONE;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ===================================================================
  // outputs
  assign prdata              = st_r.prdata;
  assign pready              = st_r.pready;
  assign pslverr             = st_r.pslverr;
  assign active_mode         = st_r.mode;
  assign active_mapping      = st_r.map;
  assign mapping_loaded      = st_r.loaded;
  assign fuse_hold_met       = st_r.hold_met;
  assign sync_ref_clock_ctrl = st_r.sync_ref;

  // ===================================================================
  // checks
  sequence s_soft_rst_write;
    wr_go && idx == `ACP_IDX_SOFT_RESET && pwdata[0];
  endsequence

  sequence s_fuse_fall;
    wr_go && idx == `ACP_IDX_FUSE_LOAD && !pwdata[0] && st_r.fuse_ctl;
  endsequence

  AST_SOFT_RESET_CLEARS: assert property (@(posedge pclk) disable iff (!presetn)
    s_soft_rst_write |=> st_r.soft_rst ##1 (!st_r.soft_rst && st_r.if_ctrl == 8'h0 && st_r.conv_ctrl == 8'h0
      && st_r.lane_ctrl == 8'h0 && !st_r.loaded))
    else $error("soft reset did not restore defaults and self-clear");

  AST_MAP_SELECT_APPLIED: assert property (@(posedge pclk) disable iff (!presetn)
    (s_fuse_fall and (st_r.if_ctrl[7:5] != 3'h0) and !st_r.soft_rst) |=> (st_r.map == $past(st_r.if_ctrl[7:5])))
    else $error("selected bit mapping not applied on fuse load");

  AST_FUSE_DEFAULT_MAP: assert property (@(posedge pclk) disable iff (!presetn)
    (s_fuse_fall and (st_r.if_ctrl[7:5] == 3'h0) and !st_r.soft_rst) |=> (st_r.loaded && st_r.map == $past(fuse_map)))
    else $error("fuse default mapping not applied on fuse load");

  AST_MAP_HELD_UNTIL_LOAD: assert property (@(posedge pclk) disable iff (!presetn)
    (!(wr_go && idx == `ACP_IDX_FUSE_LOAD && !pwdata[0] && st_r.fuse_ctl) && !st_r.soft_rst) |=> $stable(st_r.map))
    else $error("bit mapping changed without a fuse load");

  AST_MODE_DISABLED: assert property (@(posedge pclk) disable iff (!presetn)
    (!st_r.if_ctrl[3] && !st_r.soft_rst) |=> st_r.mode == ACP_TWO_LANE)
    else $error("interface mode changed while selection disabled");

  AST_MODE_SELECTED: assert property (@(posedge pclk) disable iff (!presetn)
    (st_r.if_ctrl[3] && st_r.if_ctrl[2:0] == 3'h5 && !st_r.soft_rst) |=> st_r.mode == ACP_HALF_LANE)
    else $error("half-lane mode not selected");

  AST_CONV_A_PD: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(st_r.conv_ctrl[2]) |=> converter_a_powerdown ##0 !$past(converter_a_powerdown))
    else $error("converter A power-down did not follow its bit");

  AST_CONV_B_PD: assert property (@(posedge pclk) disable iff (!presetn)
    st_r.conv_ctrl[1] |=> converter_b_powerdown)
    else $error("converter B power-down did not follow its bit");

  AST_DEVICE_PD: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(st_r.conv_ctrl[0]) |=> !whole_device_powerdown)
    else $error("whole device power-down did not release");

  AST_LANES_OWN_BITS: assert property (@(posedge pclk) disable iff (!presetn)
    (st_r.mode != ACP_TWO_LANE) |=> lane_powerdown == $past(st_r.lane_ctrl[3:0]))
    else $error("lane power-down not driven solely by its own bits");

  AST_APB_ONE_WAIT: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable) |=> pready ##1 !pready)
    else $error("access phase answer not on first access cycle");
endmodule

// [testbench/tb.sv]
`timescale 1ns/1ps
`include "acp_params.svh"

module tb;
  import acp_pkg::*;
  localparam int HOLD = 8;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  acp_mode_t   active_mode;
  logic [2:0]  active_mapping;
  logic        mapping_loaded;
  logic        fuse_hold_met;
  logic [7:0]  sync_ref_clock_ctrl;
  logic        converter_a_powerdown;
  logic        converter_b_powerdown;
  logic        whole_device_powerdown;
  logic [3:0]  lane_powerdown;
  int          miscompares;
  int          checks_done;
  logic [31:0] rd;
  logic        err;
  logic [1:0]  addr_lo;
  logic [7:0]  ifv [5] = '{8'h04, 8'h0c, 8'h0d, 8'h0e, 8'h05};
  logic [1:0]  mv  [5] = '{2'h0, 2'h1, 2'h3, 2'h0, 2'h0};
  logic [7:0]  fv  [7] = '{8'h2c, 8'h4c, 8'h60, 8'h8d, 8'h00, 8'h0c, 8'h0d};
  logic [2:0]  fm  [7] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h1, 3'h3, 3'h4};

  acp_regbank #(.FUSE_HOLD_CYCLES(HOLD)) acp_regbank_inst (
    .pclk                   (pclk),
    .presetn                (presetn),
    .psel                   (psel),
    .penable                (penable),
    .pwrite                 (pwrite),
    .paddr                  (paddr),
    .pwdata                 (pwdata),
    .prdata                 (prdata),
    .pready                 (pready),
    .pslverr                (pslverr),
    .active_mode            (active_mode),
    .active_mapping         (active_mapping),
    .mapping_loaded         (mapping_loaded),
    .fuse_hold_met          (fuse_hold_met),
    .sync_ref_clock_ctrl    (sync_ref_clock_ctrl),
    .converter_a_powerdown  (converter_a_powerdown),
    .converter_b_powerdown  (converter_b_powerdown),
    .whole_device_powerdown (whole_device_powerdown),
    .lane_powerdown         (lane_powerdown)
  );

  // =====================================================================
  // clock, checks, verdict
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d, mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // =====================================================================
  // apb master: waits for pready, no assumed latency
  task automatic apb(input logic wr, input logic [9:0] idx, input logic [7:0] wd);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {idx, addr_lo};
    pwdata  <= {24'h000000, wd};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) chk(1'b0, 1'b1, "no pready");
  endtask

  task automatic wr_ok(input logic [9:0] idx, input logic [7:0] wd);
    apb(1'b1, idx, wd);
    chk(err, 1'b0, "write error");
  endtask

  task automatic rd_chk(input logic [9:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 8'h00);
    chk(err, 1'b0, "read error");
    chk(rd, exp, "read data");
  endtask

  task automatic settle();
    repeat (3) @(posedge pclk);
    #1;
  endtask

  // mapping and mode fields first, fuse load after (software order)
  task automatic fuse_load(input logic [7:0] ifv, input logic [2:0] exp);
    wr_ok(`ACP_IDX_IF_MODE, ifv);
    wr_ok(`ACP_IDX_FUSE_LOAD, 8'h01);
    repeat (HOLD + 2) @(posedge pclk);
    #1;
    chk(fuse_hold_met, 1'b1, "hold met");
    wr_ok(`ACP_IDX_FUSE_LOAD, 8'h00);
    settle();
    chk(active_mapping, exp, "mapping");
    chk(mapping_loaded, 1'b1, "loaded");
    apb(1'b0, `ACP_IDX_STATUS, 8'h00);
    chk(rd & 32'h71, {25'h0, exp, 4'h1}, "status");
  endtask

  initial begin
    repeat (20000) @(posedge pclk);
    miscompares++;
    print_verdict();
  end

  // =====================================================================
  // tests
  initial begin
    addr_lo = 2'h0;
    miscompares = 0;
    checks_done = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    #1;
    chk({converter_a_powerdown, converter_b_powerdown, whole_device_powerdown, lane_powerdown}, 0, "pd rst");
    chk({active_mapping, mapping_loaded, active_mode}, 0, "mode rst");
    rd_chk(`ACP_IDX_SOFT_RESET, 0);
    rd_chk(`ACP_IDX_IF_MODE, 0);
    rd_chk(`ACP_IDX_CONV_POWER, 0);
    rd_chk(`ACP_IDX_LANE_POWER, 0);
    rd_chk(`ACP_IDX_SYNC_REF_CLK, 0);
    for (int i = 0; i < 3; i++) begin
      wr_ok(`ACP_IDX_CONV_POWER, 8'(1 << i));
      settle();
      chk({converter_a_powerdown, converter_b_powerdown, whole_device_powerdown}, 1 << i, "conv pd");
      rd_chk(`ACP_IDX_CONV_POWER, 1 << i);
    end
    wr_ok(`ACP_IDX_CONV_POWER, 8'h00);
    for (int i = 0; i < 4; i++) begin
      wr_ok(`ACP_IDX_LANE_POWER, 8'(1 << i));
      settle();
      chk(lane_powerdown, 1 << i, "lane pd");
      rd_chk(`ACP_IDX_LANE_POWER, 1 << i);
    end
    wr_ok(`ACP_IDX_LANE_POWER, 8'h00);
    // lanes must stay up in reduced-lane modes
    for (int i = 0; i < 5; i++) begin
      wr_ok(`ACP_IDX_IF_MODE, ifv[i]);
      settle();
      chk(active_mode, mv[i], "mode");
      chk(lane_powerdown, 4'h0, "auto lane pd");
      rd_chk(`ACP_IDX_IF_MODE, ifv[i]);
    end
    for (int i = 0; i < 7; i++) begin
      fuse_load(fv[i], fm[i]);
    end
    apb(1'b1, 10'h001, 8'h55);
    chk(err, 1'b1, "unmapped write");
    apb(1'b0, 10'h001, 8'h00);
    chk(err, 1'b1, "unmapped read error");
    chk(rd, 32'h0, "unmapped read data");
    // unaligned address must be refused and the write dropped
    addr_lo = 2'h2;
    apb(1'b1, `ACP_IDX_CONV_POWER, 8'h07);
    chk(err, 1'b1, "unaligned write");
    addr_lo = 2'h0;
    rd_chk(`ACP_IDX_CONV_POWER, 0);
    wr_ok(`ACP_IDX_CONV_POWER, 8'h07);
    wr_ok(`ACP_IDX_LANE_POWER, 8'h0f);
    wr_ok(`ACP_IDX_SYNC_REF_CLK, 8'ha5);
    wr_ok(`ACP_IDX_IF_MODE, 8'h8d);
    settle();
    chk(sync_ref_clock_ctrl, 8'ha5, "sync out");
    wr_ok(`ACP_IDX_SOFT_RESET, 8'h01);
    settle();
    chk({converter_a_powerdown, converter_b_powerdown, whole_device_powerdown, lane_powerdown}, 0, "pd soft");
    chk({active_mapping, mapping_loaded, active_mode, sync_ref_clock_ctrl}, 0, "soft rst");
    rd_chk(`ACP_IDX_SOFT_RESET, 0);
    rd_chk(`ACP_IDX_IF_MODE, 0);
    rd_chk(`ACP_IDX_LANE_POWER, 0);
    rd_chk(`ACP_IDX_SYNC_REF_CLK, 0);
    print_verdict();
  end
endmodule
